// ===== common/sbl_pkg.sv
// Package: constants, types and register map of the sensor bus link slave
package sbl_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFF_CMD     = 8'h00;
    localparam logic [7:0] OFF_RESP    = 8'h04;
    localparam logic [7:0] OFF_STATUS  = 8'h08;
    localparam logic [7:0] OFF_IRQ     = 8'h0c;
    localparam logic [7:0] OFF_MASK    = 8'h10;
    localparam logic [7:0] OFF_CTRL    = 8'h14;

    // Command word field positions (20-bit long word)
    localparam int CMD_NVW_POS   = 19;
    localparam int CMD_CLOSE_POS = 18;
    localparam int CMD_G_LSB     = 16;
    localparam int CMD_PA_LSB    = 12;
    localparam int CMD_A_LSB     = 8;
    localparam int CMD_OP_LSB    = 4;

    // Command opcodes
    localparam logic [3:0] OP_RINIT   = 4'hf;
    localparam logic [3:0] OP_FINIT   = 4'ha;
    localparam logic [3:0] OP_CLEAR   = 4'h1;
    localparam logic [3:0] GLOBAL_ADR = 4'h0;

    // Status bit positions
    localparam int ST_INIT    = 0;
    localparam int ST_GLOBAL  = 1;
    localparam int ST_SWITCH  = 2;
    localparam int ST_FAULT   = 3;
    localparam int ST_TESTING = 4;
    localparam int ST_NVW     = 5;

    // Interrupt event bit positions
    localparam int EV_RESP    = 0;
    localparam int EV_CRC     = 1;
    localparam int EV_FAULT   = 2;
    localparam int EV_CLOSED  = 3;
    localparam int EV_W       = 4;

    // Reset values
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;
    localparam logic [3:0]      ADR_RST  = 4'h0;

    // Fault test timing
    localparam int  CLK_HZ        = 40_000_000;
    localparam int  FTEST_US      = 200;
    localparam int  FTEST_CYCLES  = (CLK_HZ / 1_000_000) * FTEST_US;
    localparam int  FTEST_W       = 13;

    typedef enum logic [1:0] {
        FT_IDLE = 2'b00,
        FT_RUN  = 2'b01,
        FT_DONE = 2'b10
    } sbl_ft_state_t;

    // One received command word with its CRC field
    typedef struct packed {
        logic        nvw;
        logic        close;
        logic [1:0]  grp;
        logic [3:0]  pa;
        logic [3:0]  adr;
        logic [3:0]  op;
        logic [3:0]  crc;
    } sbl_cmd_t;

    // Fault test request and outcome
    typedef struct packed {
        logic start;
        logic reverse;
    } sbl_ft_req_t;

    typedef struct packed {
        logic done;
        logic fault;
    } sbl_ft_res_t;

endpackage

// ===== verilog/sbl_fault_test.sv
// Bus switch fault test: timed pull-down with over-voltage sampling
`timescale 1ns/1ps
module sbl_fault_test
    import sbl_pkg::*;
#(
    parameter int TEST_CYCLES = FTEST_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Request and result
    input  wire sbl_ft_req_t req,
    output sbl_ft_res_t      res,
    output logic             busy,
    // Analog side
    input  wire logic        over_up,
    input  wire logic        over_down,
    output logic             pull_up_en,
    output logic             pull_down_en
);

    sbl_ft_state_t       state;
    logic [FTEST_W-1:0]  count;
    logic                side_rev;
    logic                seen;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= FT_IDLE;
            count    <= '0;
            side_rev <= 1'b0;
            seen     <= 1'b0;
            res      <= '0;
        end else begin
            res.done <= 1'b0;
            case (state)
                FT_IDLE: begin
                    if (req.start) begin
                        state    <= FT_RUN;
                        side_rev <= req.reverse;
                        count    <= FTEST_W'(TEST_CYCLES - 1);
                        seen     <= 1'b0;
                    end
                end
                FT_RUN: begin
                    // Sample the tested side only
                    if (side_rev ? over_up : over_down) begin
                        seen <= 1'b1;
                    end
                    if (count == '0) begin
                        state <= FT_DONE;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                FT_DONE: begin
                    res.done  <= 1'b1;
                    res.fault <= seen;
                    state     <= FT_IDLE;
                end
                default: state <= FT_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pull_up_en   <= 1'b0;
            pull_down_en <= 1'b0;
        end else begin
            pull_up_en   <= (state == FT_RUN) &&  side_rev;
            pull_down_en <= (state == FT_RUN) && !side_rev;
        end
    end

    assign busy = (state != FT_IDLE);

endmodule // sbl_fault_test

// ===== verilog/sbl_link_init.sv
// Sensor bus slave: response timing, error recovery, switch test, init
//
// Summary of operation
// - Response goes out during next command message
// - Corrupted word gives silent next frame
// - Fault test once per init, only with close request
// - Close switch only if test finds no fault, or untested when both sides active
// - Test downstream on forward, upstream on reverse
// - Test regardless of programmed address
// - Skip test when both sides active
// - Global-address init takes address zero
// - Global init keeps switch open, ignores bits
// - Global init executes but never responds
// - Global init refuses re-init until Clear
// - Initialized slave ignores init until Clear
// - Upstream short reported in reverse response
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module sbl_link_init
    import sbl_pkg::*;
#(
    parameter int TEST_CYCLES = FTEST_CYCLES
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Received frame from the bus receiver
    input  wire logic        FRAME_END,
    input  wire logic [19:0] FRAME_WORD,
    input  wire logic        FRAME_CRC_OK,
    // Response word for the next frame
    output logic [15:0]      RESP_WORD,
    output logic             RESP_VALID,
    // Bus sides and switch
    input  wire logic        UPSTREAM_ACTIVE,
    input  wire logic        DOWNSTREAM_ACTIVE,
    input  wire logic        OVER_UPSTREAM,
    input  wire logic        OVER_DOWNSTREAM,
    output logic             PULL_UPSTREAM_EN,
    output logic             PULL_DOWNSTREAM_EN,
    output logic             SWITCH_CLOSED,
    output logic             HIGH_DRIVE_OUTPUT_PIN,
    // Interrupt
    output logic             IRQ
);

    // Input synchronisers
    logic [1:0]  up_act_s;
    logic [1:0]  dn_act_s;
    logic [1:0]  ov_up_s;
    logic [1:0]  ov_dn_s;

    // Link state
    sbl_cmd_t    cmd;
    logic        frame_ok;
    logic        initialized;
    logic        global_init;
    logic [3:0]  own_adr;
    logic [1:0]  group;
    logic        switch_close_request;
    logic        nonvolatile_write_allow;
    logic        bus_fault_flag;
    logic        init_rev;
    logic [15:0] pending;
    logic        pending_valid;

    // Register file
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic [EV_W-1:0] ev;
    logic            force_silent;

    // Fault test link
    sbl_ft_req_t ft_req;
    sbl_ft_res_t ft_res;
    logic        ft_busy;
    logic        ft_up_en;
    logic        ft_dn_en;

    logic        apb_wr;
    logic        apb_rd;
    logic        is_init;
    logic        addressed;

    function automatic logic [15:0] resp_of(input logic [3:0] a,
                                            input logic        fault,
                                            input logic        nvw,
                                            input logic        close,
                                            input logic [1:0]  g,
                                            input logic [3:0]  pa);
        resp_of = {a, 3'h0, fault, nvw, close, g, pa};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            up_act_s <= 2'h0;
            dn_act_s <= 2'h0;
            ov_up_s  <= 2'h0;
            ov_dn_s  <= 2'h0;
        end else begin
            up_act_s <= {up_act_s[0], UPSTREAM_ACTIVE};
            dn_act_s <= {dn_act_s[0], DOWNSTREAM_ACTIVE};
            ov_up_s  <= {ov_up_s[0], OVER_UPSTREAM};
            ov_dn_s  <= {ov_dn_s[0], OVER_DOWNSTREAM};
        end
    end

    assign cmd       = FRAME_WORD;
    assign frame_ok  = FRAME_END && FRAME_CRC_OK;
    assign is_init   = (cmd.op == OP_FINIT) || (cmd.op == OP_RINIT);
    assign addressed = (cmd.adr == own_adr);
    assign apb_wr    = PSEL && PENABLE && PWRITE;
    assign apb_rd    = PSEL && !PWRITE;

    ////////////////////////////////////////////////////////////////////////
    // Initialization and Clear handling
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            initialized             <= 1'b0;
            global_init             <= 1'b0;
            own_adr                 <= ADR_RST;
            group                   <= 2'h0;
            switch_close_request    <= 1'b0;
            nonvolatile_write_allow <= 1'b0;
            init_rev                <= 1'b0;
        end else if (frame_ok) begin
            if (cmd.op == OP_CLEAR && addressed) begin
                initialized             <= 1'b0;
                global_init             <= 1'b0;
                own_adr                 <= ADR_RST;
                switch_close_request    <= 1'b0;
                nonvolatile_write_allow <= 1'b0;
            end else if (is_init && !initialized) begin
                initialized <= 1'b1;
                init_rev    <= (cmd.op == OP_RINIT);
                if (cmd.adr == GLOBAL_ADR) begin
                    global_init             <= 1'b1;
                    own_adr                 <= GLOBAL_ADR;
                    switch_close_request    <= 1'b0;
                    nonvolatile_write_allow <= 1'b0;
                end else begin
                    own_adr                 <= cmd.pa;
                    group                   <= cmd.grp;
                    switch_close_request    <= cmd.close;
                    nonvolatile_write_allow <= cmd.nvw;
                end
            end
        end
    end

    // Start test once per accepted init, no matter if programmed
    assign ft_req.start   = frame_ok && is_init && !initialized && cmd.adr != GLOBAL_ADR
                            && cmd.close && !(up_act_s[1] && dn_act_s[1]);
    assign ft_req.reverse = (cmd.op == OP_RINIT);

    sbl_fault_test #(
        .TEST_CYCLES (TEST_CYCLES)
    ) u_ftest (
        .clk          (CLOCK),
        .rst          (RST),
        .req          (ft_req),
        .res          (ft_res),
        .busy         (ft_busy),
        .over_up      (ov_up_s[1]),
        .over_down    (ov_dn_s[1]),
        .pull_up_en   (ft_up_en),
        .pull_down_en (ft_dn_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // Switch and fault flag
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            SWITCH_CLOSED  <= 1'b0;
            bus_fault_flag <= 1'b0;
        end else if (frame_ok && cmd.op == OP_CLEAR && addressed) begin
            SWITCH_CLOSED  <= 1'b0;
            bus_fault_flag <= 1'b0;
        end else if (ft_res.done) begin
            SWITCH_CLOSED  <= !ft_res.fault && !global_init;
            bus_fault_flag <= ft_res.fault && init_rev;
        end else if (frame_ok && is_init && !initialized && cmd.adr != GLOBAL_ADR
                     && cmd.close && up_act_s[1] && dn_act_s[1]) begin
            SWITCH_CLOSED <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pull-down drive and high-drive output
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PULL_UPSTREAM_EN      <= 1'b0;
            PULL_DOWNSTREAM_EN    <= 1'b0;
            HIGH_DRIVE_OUTPUT_PIN <= 1'b0;
        end else begin
            PULL_UPSTREAM_EN   <= ft_up_en;
            PULL_DOWNSTREAM_EN <= ft_dn_en;
            if (frame_ok && initialized && addressed) begin
                // Executed even after a global init
                if (cmd.op == OP_CLEAR) begin
                    HIGH_DRIVE_OUTPUT_PIN <= 1'b0;
                end else if (cmd.op == 4'hc) begin
                    HIGH_DRIVE_OUTPUT_PIN <= cmd.crc[3];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response staging: prepared now, shifted out during the next frame
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pending       <= 16'h0000;
            pending_valid <= 1'b0;
        end else if (FRAME_END) begin
            if (!FRAME_CRC_OK || force_silent) begin
                pending       <= 16'h0000;
                pending_valid <= 1'b0;
            end else if (is_init && !initialized && cmd.adr != GLOBAL_ADR) begin
                pending       <= resp_of(cmd.pa, 1'b0, cmd.nvw, cmd.close, 2'h0, cmd.pa);
                pending_valid <= 1'b1;
            end else if (initialized && addressed && !global_init) begin
                pending       <= resp_of(own_adr, bus_fault_flag, nonvolatile_write_allow,
                                         SWITCH_CLOSED, 2'h0, own_adr);
                pending_valid <= 1'b1;
            end else begin
                pending       <= 16'h0000;
                pending_valid <= 1'b0;
            end
        end
    end

    // Word presented across the whole following message
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            RESP_WORD  <= 16'h0000;
            RESP_VALID <= 1'b0;
        end else begin
            RESP_WORD  <= pending;
            RESP_VALID <= pending_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events and interrupt
    assign ev[EV_RESP]   = FRAME_END && frame_ok;
    assign ev[EV_CRC]    = FRAME_END && !FRAME_CRC_OK;
    assign ev[EV_FAULT]  = ft_res.done && ft_res.fault;
    assign ev[EV_CLOSED] = ft_res.done && !ft_res.fault;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            irq_stat     <= '0;
            irq_mask     <= MASK_RST;
            force_silent <= 1'b0;
        end else begin
            // Set wins over write-one-to-clear
            if (apb_wr && PADDR == OFF_IRQ) begin
                irq_stat <= (irq_stat & ~PWDATA[EV_W-1:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            if (apb_wr && PADDR == OFF_MASK) begin
                irq_mask <= PWDATA[EV_W-1:0];
            end
            if (apb_wr && PADDR == OFF_CTRL) begin
                force_silent <= PWDATA[0];
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |((irq_stat | ev) & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB: answers in the access cycle after setup, no wait states
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !(PADDR inside {OFF_CMD, OFF_RESP, OFF_STATUS,
                                                          OFF_IRQ, OFF_MASK, OFF_CTRL});
            PRDATA  <= 32'h0000_0000;
            if (apb_rd && !PENABLE) begin
                case (PADDR)
                    OFF_CMD:    PRDATA <= {20'h00000, own_adr, 2'h0, group,
                                           3'h0, initialized};
                    OFF_RESP:   PRDATA <= {15'h0000, pending_valid, pending};
                    OFF_STATUS: PRDATA <= {26'h0000000, nonvolatile_write_allow, ft_busy,
                                           bus_fault_flag, SWITCH_CLOSED, global_init,
                                           initialized};
                    OFF_IRQ:    PRDATA <= {28'h0000000, irq_stat};
                    OFF_MASK:   PRDATA <= {28'h0000000, irq_mask};
                    OFF_CTRL:   PRDATA <= {31'h00000000, force_silent};
                    default:    PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // sbl_link_init

// ===== dv/sbl_link_init_chk.sv
// Checker: port-level timing of the link slave
`timescale 1ns/1ps
module sbl_link_chk
    import sbl_pkg::*;
#(
    parameter int TEST_CYCLES = FTEST_CYCLES
) (
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        RST,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Frame link
    input wire logic        FRAME_END,
    input wire logic [19:0] FRAME_WORD,
    input wire logic        FRAME_CRC_OK,
    input wire logic        RESP_VALID,
    // Bus sides
    input wire logic        UPSTREAM_ACTIVE,
    input wire logic        DOWNSTREAM_ACTIVE,
    input wire logic        PULL_UPSTREAM_EN,
    input wire logic        PULL_DOWNSTREAM_EN
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    logic [15:0] pull_cnt;
    logic        pull_any;
    assign pull_any = PULL_UPSTREAM_EN || PULL_DOWNSTREAM_EN;
    // Length of the current test pull-down
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pull_cnt <= 16'h0;
        end else if (pull_any) begin
            pull_cnt <= pull_cnt + 16'h1;
        end else begin
            pull_cnt <= 16'h0;
        end
    end
    chk_apb_ready: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready in access cycle");
    chk_ready_once: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    chk_slverr_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error without ready or with data");
    chk_resp_timing: assert property (
        $changed(RESP_VALID) |-> $past(FRAME_END, 2) || $past(FRAME_END, 3))
        else $error("response changed off frame");
    chk_crc_silent: assert property (FRAME_END && !FRAME_CRC_OK |-> ##3 !RESP_VALID)
        else $error("response after bad word");
    chk_global_silent: assert property (
        FRAME_END && FRAME_WORD[11:8] == 4'h0 |-> ##3 !RESP_VALID)
        else $error("response at address zero");
    chk_one_side: assert property (!(PULL_UPSTREAM_EN && PULL_DOWNSTREAM_EN))
        else $error("both sides pulled");
    chk_test_max: assert property (pull_cnt <= TEST_CYCLES + 2)
        else $error("fault test too long");
    chk_test_min: assert property ($fell(pull_any) |-> $past(pull_cnt) >= TEST_CYCLES - 2)
        else $error("fault test too short");
    chk_loop_skip: assert property (
        (UPSTREAM_ACTIVE && DOWNSTREAM_ACTIVE) [*4] |-> !pull_any)
        else $error("test run in loop-back");
endmodule // sbl_link_chk

bind sbl_link_init sbl_link_chk #(.TEST_CYCLES(TEST_CYCLES)) u_chk (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .FRAME_END(FRAME_END), .FRAME_WORD(FRAME_WORD),
    .FRAME_CRC_OK(FRAME_CRC_OK), .RESP_VALID(RESP_VALID), .UPSTREAM_ACTIVE(UPSTREAM_ACTIVE),
    .DOWNSTREAM_ACTIVE(DOWNSTREAM_ACTIVE), .PULL_UPSTREAM_EN(PULL_UPSTREAM_EN),
    .PULL_DOWNSTREAM_EN(PULL_DOWNSTREAM_EN)
);

// ===== dv/sbl_master_mdl.sv
// Command master model: one word per frame, word and CRC flag inverted between frames
`timescale 1ns/1ps
module sbl_master_mdl (
    // Clock
    input  wire logic   clk,
    // Frame outputs
    output logic        frame_end,
    output logic [19:0] frame_word,
    output logic        crc_ok
);
    initial begin
        frame_end  = 1'b0;
        frame_word = 20'h0;
        crc_ok     = 1'b0;
    end
    task automatic send(input logic [19:0] w, input logic ok);
        @(posedge clk);
        frame_end  <= 1'b1;
        frame_word <= w;
        crc_ok     <= ok;
        @(posedge clk);
        frame_end  <= 1'b0;
        frame_word <= ~w;
        crc_ok     <= ~ok;
        repeat (3) @(posedge clk);
    endtask
endmodule // sbl_master_mdl

// ===== dv/tb_top.sv
// Testbench: frame link, fault test, global init and registers
`timescale 1ns/1ps
module tb_top;
    import sbl_pkg::*;
    localparam int TC = 10;
    logic        CLOCK = 1'b0;
    logic        RST = 1'b1;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h0;
    logic [31:0] PWDATA = 32'h0;
    logic        UP_ACT = 1'b0;
    logic        DN_ACT = 1'b1;
    logic        OVER_UP = 1'b0;
    logic        OVER_DN = 1'b0;
    logic [31:0] PRDATA, rd, v;
    logic [19:0] FRAME_WORD;
    logic [15:0] RESP_WORD;
    logic        PREADY, PSLVERR, FRAME_END, FRAME_CRC_OK, RESP_VALID, err, lv;
    logic        PULL_UP, PULL_DN, SWITCH_CLOSED, HIGH_DRIVE_OUTPUT_PIN, IRQ;
    logic [3:0]  a;
    int          miscompares = 0;
    int          n_tests = 0;
    always #12.5 CLOCK = ~CLOCK;
    sbl_master_mdl u_mst (.clk(CLOCK), .frame_end(FRAME_END), .frame_word(FRAME_WORD),
        .crc_ok(FRAME_CRC_OK));
    sbl_link_init #(.TEST_CYCLES(TC)) u_dut (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FRAME_END(FRAME_END),
        .FRAME_WORD(FRAME_WORD), .FRAME_CRC_OK(FRAME_CRC_OK), .RESP_WORD(RESP_WORD),
        .RESP_VALID(RESP_VALID), .UPSTREAM_ACTIVE(UP_ACT), .DOWNSTREAM_ACTIVE(DN_ACT),
        .OVER_UPSTREAM(OVER_UP), .OVER_DOWNSTREAM(OVER_DN), .PULL_UPSTREAM_EN(PULL_UP),
        .PULL_DOWNSTREAM_EN(PULL_DN), .SWITCH_CLOSED(SWITCH_CLOSED),
        .HIGH_DRIVE_OUTPUT_PIN(HIGH_DRIVE_OUTPUT_PIN), .IRQ(IRQ));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge CLOCK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= ad;
        PWDATA  <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin
            miscompares++;
            finish_test();
        end
        rd  = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    function automatic logic [19:0] cw(logic nvw, logic cls, logic [3:0] pa, logic [3:0] ad,
                                       logic [3:0] op, logic [3:0] c);
        return {nvw, cls, 2'b00, pa, ad, op, c};
    endfunction
    task automatic wait_pull(input logic up);
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge CLOCK);
            if ((up ? PULL_UP : PULL_DN) === 1'b1) break;
        end
        chk({31'h0, n < 20}, 32'h1);
    endtask
    task automatic settle;
        repeat (TC + 8) @(posedge CLOCK);
    endtask
    task automatic bus(input logic up, input logic dn, input logic [19:0] w);
        UP_ACT <= up;
        DN_ACT <= dn;
        repeat (4) @(posedge CLOCK);
        u_mst.send(w, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge CLOCK);
        miscompares++;
        $display("[FAIL] %0t run timed out", $time);
        finish_test();
    end
    initial begin
        void'($urandom(32'hfa38));
        repeat (8) @(posedge CLOCK);
        RST <= 1'b0;
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, OFF_MASK, 32'h0);
        chk(rd, 32'h0);
        v = $urandom;
        apb(1'b1, OFF_MASK, v);
        apb(1'b0, OFF_MASK, 32'h0);
        chk(rd, v & 32'hf);
        apb(1'b1, OFF_MASK, 32'h2);
        u_mst.send(cw(1'b0, 1'b0, 4'h0, 4'h5, 4'hc, 4'h0), 1'b0);
        chk({31'h0, RESP_VALID}, 32'h0);
        repeat (2) @(posedge CLOCK);
        chk({31'h0, IRQ}, 32'h1);
        apb(1'b1, OFF_MASK, 32'h0);
        apb(1'b0, OFF_IRQ, 32'h0);
        chk({31'h0, IRQ}, 32'h0);
        chk(rd & 32'h2, 32'h2);
        apb(1'b1, OFF_IRQ, 32'h2);
        apb(1'b0, OFF_IRQ, 32'h0);
        chk(rd & 32'h2, 32'h0);
        u_mst.send(cw(1'b0, 1'b0, 4'h0, 4'h5, 4'hc, 4'h0), 1'b1);
        a = 4'($urandom_range(15, 1));
        bus(1'b1, 1'b0, cw(1'b0, 1'b1, a, a, OP_FINIT, 4'h0));
        chk({15'h0, RESP_VALID, RESP_WORD}, {16'h1, a, 4'h0, 2'b01, 2'b00, a});
        wait_pull(1'b0);
        settle();
        chk({31'h0, SWITCH_CLOSED}, 32'h1);
        u_mst.send(cw(1'b0, 1'b1, ~a, ~a, OP_RINIT, 4'h0), 1'b1);
        apb(1'b0, OFF_CMD, 32'h0);
        chk(rd & 32'hf01, {20'h0, a, 8'h01});
        u_mst.send(cw(1'b0, 1'b0, 4'h0, a, OP_CLEAR, 4'h0), 1'b1);
        OVER_UP <= 1'b1;
        bus(1'b0, 1'b1, cw(1'b0, 1'b1, 4'h3, 4'h3, OP_RINIT, 4'h0));
        wait_pull(1'b1);
        settle();
        chk({31'h0, SWITCH_CLOSED}, 32'h0);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk({31'h0, rd[ST_FAULT]}, 32'h1);
        OVER_UP <= 1'b0;
        u_mst.send(cw(1'b0, 1'b0, 4'h0, 4'h3, 4'hc, 4'h0), 1'b1);
        chk({30'h0, RESP_VALID, RESP_WORD[8]}, 32'h3);
        u_mst.send(cw(1'b0, 1'b0, 4'h0, 4'h3, 4'hc, 4'h0), 1'b0);
        chk({31'h0, RESP_VALID}, 32'h0);
        u_mst.send(cw(1'b0, 1'b0, 4'h0, 4'h3, 4'hc, 4'h0), 1'b1);
        apb(1'b1, OFF_CTRL, 32'h1);
        u_mst.send(cw(1'b0, 1'b0, 4'h0, 4'h3, 4'hc, 4'h0), 1'b1);
        chk({31'h0, RESP_VALID}, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0);
        u_mst.send(cw(1'b0, 1'b0, 4'h0, 4'h3, OP_CLEAR, 4'h0), 1'b1);
        OVER_DN <= 1'b1;
        bus(1'b1, 1'b1, cw(1'b0, 1'b1, 4'h4, 4'h4, OP_FINIT, 4'h0));
        settle();
        chk({31'h0, SWITCH_CLOSED}, 32'h1);
        u_mst.send(cw(1'b0, 1'b0, 4'h0, 4'h4, OP_CLEAR, 4'h0), 1'b1);
        bus(1'b1, 1'b0, cw(1'b1, 1'b1, 4'h0, 4'h0, OP_FINIT, 4'h0));
        chk({31'h0, RESP_VALID}, 32'h0);
        settle();
        chk({31'h0, SWITCH_CLOSED}, 32'h0);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk({31'h0, rd[ST_NVW]}, 32'h0);
        apb(1'b0, OFF_CMD, 32'h0);
        chk(rd & 32'hf01, 32'h001);
        u_mst.send(cw(1'b0, 1'b1, 4'h6, 4'h6, OP_RINIT, 4'h0), 1'b1);
        apb(1'b0, OFF_CMD, 32'h0);
        chk(rd & 32'hf01, 32'h001);
        for (int i = 0; i < 4; i++) begin
            lv = 1'($urandom_range(1, 0));
            u_mst.send(cw(1'b0, 1'b0, 4'h0, 4'h0, 4'hc, {lv, 3'b000}), 1'b1);
            chk({31'h0, HIGH_DRIVE_OUTPUT_PIN}, {31'h0, lv});
            chk({31'h0, RESP_VALID}, 32'h0);
        end
        finish_test();
    end
endmodule // tb_top
